//--- hdl/bus_gate_pkg.sv
/*
 * constants for the peripheral bus clock gating block: register indices,
 * field layouts, reset values and bus widths.
 * assumes a 32-bit APB register port; byte address is four times the index.
 */
package bus_gate_pkg;

    // ************************************************************
    // bus geometry
    // ************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // register indices as printed, byte address = index * 4
    localparam logic [ADDR_W-1:0] IDX_SECOND_MASK = 8'h1C;
    localparam logic [ADDR_W-1:0] IDX_THIRD_MASK  = 8'h20;
    localparam logic [ADDR_W-1:0] IDX_IRQ_CLEAR   = 8'h34;
    localparam logic [ADDR_W-1:0] IDX_IRQ_SET     = 8'h35;
    localparam logic [ADDR_W-1:0] IDX_IRQ_STATUS  = 8'h36;
    localparam logic [ADDR_W-1:0] IDX_STATUS_CLR  = 8'h37;

    // ************************************************************
    // field layouts and reset values
    // ************************************************************
    localparam int SECOND_W = 5;   // bits 4:0 implemented
    localparam int THIRD_W  = 20;  // bits 19:0 implemented

    localparam logic [DATA_W-1:0] SECOND_RESET = 32'h0000_007F;
    localparam logic [DATA_W-1:0] THIRD_RESET  = 32'h0001_0000;
    localparam logic [7:0]        IRQ_EN_RESET = 8'h00;

    localparam int SETTLED_BIT = 0;

    // second bus bit positions
    localparam int B_ACCESS_GUARD_ONE = 0;
    localparam int B_DEBUG_SERVICE    = 1;
    localparam int B_FLASH_CTL        = 2;
    localparam int B_IO_PORT          = 3;
    localparam int B_DMA_CTL          = 4;

    // third bus bit positions
    localparam int C_ACCESS_GUARD_TWO = 0;
    localparam int C_EVENT_ROUTING    = 1;
    localparam int C_SERIAL_LO        = 2;   // serial units 0..5 at 2..7
    localparam int C_CTL_TIMER_LO     = 8;   // control timers 0..2 at 8..10
    localparam int C_TIMER_LO         = 11;  // timers 3..7 at 11..15
    localparam int C_ADC              = 16;
    localparam int C_ANALOG_CMP       = 17;
    localparam int C_DAC              = 18;
    localparam int C_TOUCH_CTL        = 19;

endpackage

//--- hdl/gate_mask_if.sv
/*
 * carries the two clock mask words from the register file to the
 * enable stage.
 * assumes both ends run on the same clock.
 */
`timescale 1ns/100ps
`default_nettype none

interface gate_mask_if;
    import bus_gate_pkg::*;

    logic [SECOND_W-1:0] second_mask;
    logic [THIRD_W-1:0]  third_mask;

    modport source (output second_mask, output third_mask);
    modport sink   (input second_mask, input third_mask);
endinterface

`default_nettype wire

//--- hdl/clock_enable_stage.sv
/*
 * registers the mask words into the per-peripheral bus clock enables.
 * assumes the peripherals qualify their bus clock with these enables.
 */
`timescale 1ns/100ps
`default_nettype none

module clock_enable_stage
    import bus_gate_pkg::*;
(
    // clock and reset
    input  wire logic            clk,
    input  wire logic            rst_n,
    // masks from the register file
    gate_mask_if.sink            masks,
    // per-peripheral enables
    output logic [SECOND_W-1:0]  second_en,
    output logic [THIRD_W-1:0]   third_en
);

    logic [SECOND_W-1:0] second_en_reg;
    logic [SECOND_W-1:0] second_en_next;
    logic [THIRD_W-1:0]  third_en_reg;
    logic [THIRD_W-1:0]  third_en_next;

    // one on a bit passes the clock, zero stops it
    always_comb begin
        second_en_next = masks.second_mask;
        third_en_next  = masks.third_mask;
    end

    // registered so enables change glitch-free at a clock edge
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            second_en_reg <= SECOND_RESET[SECOND_W-1:0];
            third_en_reg  <= THIRD_RESET[THIRD_W-1:0];
        end else begin
            second_en_reg <= second_en_next;
            third_en_reg  <= third_en_next;
        end
    end

    assign second_en = second_en_reg;
    assign third_en  = third_en_reg;

endmodule

`default_nettype wire

//--- hdl/bus_clock_gating.sv
/*
 * peripheral bus clock gating: two mask registers and the clock-ready
 * interrupt enable with its set/clear pair, behind an APB slave.
 * assumes a single 200 MHz clock, synchronous inputs and an APB master
 * that holds each request until pready.
 */
`timescale 1ns/100ps
`default_nettype none

module bus_clock_gating
    import bus_gate_pkg::*;
(
    // clock and reset
    input  wire logic              CLK,
    input  wire logic              RST_B,
    // apb slave
    input  wire logic              PSEL,
    input  wire logic              PENABLE,
    input  wire logic              PWRITE,
    input  wire logic [ADDR_W-1:0] PADDR,
    input  wire logic [DATA_W-1:0] PWDATA,
    output logic [DATA_W-1:0]      PRDATA,
    output logic                   PREADY,
    output logic                   PSLVERR,
    // protection and clock status
    input  wire logic              WRITE_LOCK,
    input  wire logic              CLOCKS_SETTLED,
    // interrupt
    output logic                   IRQ,
    // gated bus clock enables
    output logic [SECOND_W-1:0]    SECOND_BUS_CLK_EN,
    output logic [THIRD_W-1:0]     THIRD_BUS_CLK_EN
);

    // ************************************************************
    // reset release
    // ************************************************************
    logic rst_meta_reg;
    logic rst_n;

    // assert at once, release after two edges
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_reg <= 1'b0;
            rst_n        <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n        <= rst_meta_reg;
        end
    end

    // ************************************************************
    // address decode
    // ************************************************************
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [ADDR_W-1:0] idx);
        // word aligned, index times four
        hit = (addr[1:0] == 2'b00) && (addr[ADDR_W-1:2] == idx[ADDR_W-3:0]);
    endfunction

    logic setup;
    logic access;
    logic wr_ok;
    logic mapped;

    assign setup  = PSEL && !PENABLE;
    assign access = PSEL && PENABLE;
    assign mapped = hit(PADDR, IDX_SECOND_MASK) || hit(PADDR, IDX_THIRD_MASK)
                 || hit(PADDR, IDX_IRQ_CLEAR)   || hit(PADDR, IDX_IRQ_SET)
                 || hit(PADDR, IDX_IRQ_STATUS)  || hit(PADDR, IDX_STATUS_CLR);
    assign wr_ok  = access && PWRITE && !WRITE_LOCK;

    // ************************************************************
    // register file
    // ************************************************************
    logic [SECOND_W-1:0] second_mask_reg;
    logic [SECOND_W-1:0] second_mask_next;
    logic [THIRD_W-1:0]  third_mask_reg;
    logic [THIRD_W-1:0]  third_mask_next;
    logic                irq_en_reg;
    logic                irq_en_next;
    logic                flag_reg;
    logic                flag_next;

    // next values; lock blocks every write, set of the flag beats its clear
    always_comb begin
        second_mask_next = second_mask_reg;
        third_mask_next  = third_mask_reg;
        irq_en_next      = irq_en_reg;
        flag_next        = flag_reg;
        if (wr_ok && hit(PADDR, IDX_SECOND_MASK)) begin
            second_mask_next = PWDATA[SECOND_W-1:0];
        end
        if (wr_ok && hit(PADDR, IDX_THIRD_MASK)) begin
            third_mask_next = PWDATA[THIRD_W-1:0];
        end
        if (wr_ok && hit(PADDR, IDX_IRQ_CLEAR) && PWDATA[SETTLED_BIT]) begin
            irq_en_next = 1'b0;
        end
        if (wr_ok && hit(PADDR, IDX_IRQ_SET) && PWDATA[SETTLED_BIT]) begin
            irq_en_next = 1'b1;
        end
        if (wr_ok && hit(PADDR, IDX_STATUS_CLR) && PWDATA[SETTLED_BIT]) begin
            flag_next = 1'b0;
        end
        if (CLOCKS_SETTLED) begin
            flag_next = 1'b1;
        end
    end

    // reset values leave the second bus running, only the ADC on the third
    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            second_mask_reg <= SECOND_RESET[SECOND_W-1:0];
            third_mask_reg  <= THIRD_RESET[THIRD_W-1:0];
            irq_en_reg      <= IRQ_EN_RESET[SETTLED_BIT];
            flag_reg        <= 1'b0;
        end else begin
            second_mask_reg <= second_mask_next;
            third_mask_reg  <= third_mask_next;
            irq_en_reg      <= irq_en_next;
            flag_reg        <= flag_next;
        end
    end

    // ************************************************************
    // read path
    // ************************************************************
    logic [DATA_W-1:0] rdata_reg;
    logic [DATA_W-1:0] rdata_next;

    // data picked in the setup cycle so it is a flop in the access cycle
    always_comb begin
        rdata_next = rdata_reg;
        if (setup) begin
            rdata_next = '0;
            if (hit(PADDR, IDX_SECOND_MASK)) begin
                rdata_next[SECOND_W-1:0] = second_mask_reg;
            end else if (hit(PADDR, IDX_THIRD_MASK)) begin
                rdata_next[THIRD_W-1:0] = third_mask_reg;
            end else if (hit(PADDR, IDX_IRQ_CLEAR) || hit(PADDR, IDX_IRQ_SET)) begin
                rdata_next[SETTLED_BIT] = irq_en_reg;
            end else if (hit(PADDR, IDX_IRQ_STATUS)) begin
                rdata_next[SETTLED_BIT] = flag_reg;
            end
        end
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            rdata_reg <= '0;
        end else begin
            rdata_reg <= rdata_next;
        end
    end

    // zero wait states; error on any unmapped access, read or write, or on a locked-out write
    assign PRDATA  = rdata_reg;
    assign PREADY  = 1'b1;
    assign PSLVERR = access && (!mapped || (PWRITE && WRITE_LOCK));

    // ************************************************************
    // interrupt and clock enables
    // ************************************************************
    logic irq_reg;
    logic irq_next;

    // clearing the enable withdraws the request at the same edge
    always_comb begin
        irq_next = irq_en_next && flag_next;
    end

    always_ff @(posedge CLK or negedge rst_n) begin
        if (!rst_n) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= irq_next;
        end
    end

    assign IRQ = irq_reg;

    gate_mask_if masks ();

    assign masks.second_mask = second_mask_reg;
    assign masks.third_mask  = third_mask_reg;

    clock_enable_stage clock_enable_stage_i (
        .clk       (CLK),
        .rst_n     (rst_n),
        .masks     (masks),
        .second_en (SECOND_BUS_CLK_EN),
        .third_en  (THIRD_BUS_CLK_EN)
    );

    // ************************************************************
    // checks
    // ************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!rst_n);

    property p_second_gate;
        wr_ok && hit(PADDR, IDX_SECOND_MASK)
            |=> ##1 SECOND_BUS_CLK_EN == $past(PWDATA[SECOND_W-1:0], 2);
    endproperty
    a_second_gate: assert property (p_second_gate)
        else $error("second bus enables do not follow the mask write");

    property p_second_read;
        setup && hit(PADDR, IDX_SECOND_MASK)
            |=> PRDATA == {{(DATA_W-SECOND_W){1'b0}}, $past(second_mask_reg)};
    endproperty
    a_second_read: assert property (p_second_read)
        else $error("second mask readback wrong");

    property p_third_gate;
        wr_ok && hit(PADDR, IDX_THIRD_MASK)
            |=> ##1 THIRD_BUS_CLK_EN == $past(PWDATA[THIRD_W-1:0], 2);
    endproperty
    a_third_gate: assert property (p_third_gate)
        else $error("third bus enables do not follow the mask write");

    property p_third_reserved;
        setup && hit(PADDR, IDX_THIRD_MASK) |=> PRDATA[DATA_W-1:THIRD_W] == '0;
    endproperty
    a_third_reserved: assert property (p_third_reserved)
        else $error("third mask reserved bits not zero");

    property p_clear_en;
        wr_ok && hit(PADDR, IDX_IRQ_CLEAR) && PWDATA[SETTLED_BIT]
            |=> !irq_en_reg && !IRQ;
    endproperty
    a_clear_en: assert property (p_clear_en)
        else $error("clear write left the enable or request up");

    property p_zero_write;
        wr_ok && (hit(PADDR, IDX_IRQ_CLEAR) || hit(PADDR, IDX_IRQ_SET))
            && !PWDATA[SETTLED_BIT] |=> $stable(irq_en_reg);
    endproperty
    a_zero_write: assert property (p_zero_write)
        else $error("writing zero changed the enable");

    property p_set_en;
        wr_ok && hit(PADDR, IDX_IRQ_SET) && PWDATA[SETTLED_BIT] |=> irq_en_reg;
    endproperty
    a_set_en: assert property (p_set_en)
        else $error("set write not seen as enable");

    // both halves of the pair read back the one shared enable
    property p_enable_read;
        setup && (hit(PADDR, IDX_IRQ_CLEAR) || hit(PADDR, IDX_IRQ_SET))
            |=> PRDATA == {{(DATA_W-1){1'b0}}, $past(irq_en_reg)};
    endproperty
    a_enable_read: assert property (p_enable_read)
        else $error("enable readback wrong");

    property p_irq_gate;
        !irq_en_reg |-> !IRQ;
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("request raised while disabled");

    property p_flag_set;
        CLOCKS_SETTLED && irq_en_reg && !(wr_ok && hit(PADDR, IDX_IRQ_CLEAR))
            |=> flag_reg && IRQ;
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("settle event did not raise flag and request");

    property p_flag_clear;
        wr_ok && hit(PADDR, IDX_STATUS_CLR) && PWDATA[SETTLED_BIT] && !CLOCKS_SETTLED
            |=> !flag_reg && !IRQ;
    endproperty
    a_flag_clear: assert property (p_flag_clear)
        else $error("status clear left the flag or request up");

    // a settle event in the clear cycle must not be lost
    property p_settle_wins;
        CLOCKS_SETTLED |=> flag_reg;
    endproperty
    a_settle_wins: assert property (p_settle_wins)
        else $error("settle event lost to a status clear");

    property p_lock;
        access && PWRITE && WRITE_LOCK && !CLOCKS_SETTLED
            |=> $stable(second_mask_reg) && $stable(third_mask_reg)
                && $stable(irq_en_reg) && $stable(flag_reg);
    endproperty
    a_lock: assert property (p_lock)
        else $error("locked write changed a register");

endmodule

`default_nettype wire

//--- dv/periph_clock_sink.sv
/*
 * far-side model: the peripherals record which gated bus clocks ticked.
 * assumes the enables qualify the block clock edge by edge.
 */
`timescale 1ns/100ps
`default_nettype none

module periph_clock_sink
    import bus_gate_pkg::*;
(
    // clock and clear
    input  wire logic                clk,
    input  wire logic                clr,
    // gated clock enables
    input  wire logic [SECOND_W-1:0] second_en,
    input  wire logic [THIRD_W-1:0]  third_en,
    // peripherals that saw a tick
    output logic [SECOND_W-1:0]      second_seen,
    output logic [THIRD_W-1:0]       third_seen
);
    // sticky record; a stopped clock never marks its peripheral
    always_ff @(posedge clk) begin
        second_seen <= clr ? '0 : (second_seen | second_en);
        third_seen  <= clr ? '0 : (third_seen | third_en);
    end
endmodule

`default_nettype wire

//--- dv/peripheral_bus_clock_gating_bench.sv
/*
 * self-checking bench: apb tasks, mask, interrupt and lock sequences.
 * assumes bus_gate_pkg, the design and periph_clock_sink compiled first.
 */
`timescale 1ns/100ps
`default_nettype none

module peripheral_bus_clock_gating_bench
    import bus_gate_pkg::*;
;
    localparam logic [ADDR_W-1:0] A_SECOND = IDX_SECOND_MASK << 2;
    localparam logic [ADDR_W-1:0] A_THIRD  = IDX_THIRD_MASK << 2;
    localparam logic [ADDR_W-1:0] A_CLEAR  = IDX_IRQ_CLEAR << 2;
    localparam logic [ADDR_W-1:0] A_SET    = IDX_IRQ_SET << 2;
    localparam logic [ADDR_W-1:0] A_STATUS = IDX_IRQ_STATUS << 2;
    localparam logic [ADDR_W-1:0] A_STCLR  = IDX_STATUS_CLR << 2;

    logic                clk = 1'b0;
    logic                rst_b = 1'b0;
    logic                psel = 1'b0;
    logic                penable = 1'b0;
    logic                pwrite = 1'b0;
    logic [ADDR_W-1:0]   paddr = '0;
    logic [DATA_W-1:0]   pwdata = '0;
    logic                write_lock = 1'b0;
    logic                clocks_settled = 1'b0;
    logic                sink_clr = 1'b0;
    logic [DATA_W-1:0]   prdata;
    logic                pready;
    logic                pslverr;
    logic                irq;
    logic [SECOND_W-1:0] second_en;
    logic [THIRD_W-1:0]  third_en;
    logic [SECOND_W-1:0] second_seen;
    logic [THIRD_W-1:0]  third_seen;
    int                  err_count = 0;
    int                  checked = 0;
    int                  cycles = 0;

    bus_clock_gating bus_clock_gating_i (
        .CLK(clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
        .PSLVERR(pslverr), .WRITE_LOCK(write_lock), .CLOCKS_SETTLED(clocks_settled),
        .IRQ(irq), .SECOND_BUS_CLK_EN(second_en), .THIRD_BUS_CLK_EN(third_en));

    periph_clock_sink periph_clock_sink_i (
        .clk(clk), .clr(sink_clr), .second_en(second_en), .third_en(third_en),
        .second_seen(second_seen), .third_seen(third_seen));

    // free-running 200 MHz clock
    initial begin
        forever #2.5 clk = ~clk;
    end

    // hang guard; the sequence needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic close_out();
        if (err_count == 0 && checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask

    // one apb transfer; an idle edge after it keeps strobes from double assignment
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rdat, output logic err);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b1, a, d, r, x);
        chk("write error", {31'h0000_0000, e}, {31'h0000_0000, x});
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic e);
        logic [31:0] r;
        logic        x;
        apb(1'b0, a, 32'h0000_0000, r, x);
        chk("read data", exp, r);
        chk("read error", {31'h0000_0000, e}, {31'h0000_0000, x});
    endtask

    // irq may come from a register, so let two edges land first
    task automatic chk_irq(input logic exp);
        repeat (2) @(posedge clk);
        chk("irq", {31'h0000_0000, exp}, {31'h0000_0000, irq});
    endtask

    task automatic chk_seen(input logic [31:0] s2, input logic [31:0] s3);
        sink_clr <= 1'b1;
        @(posedge clk);
        sink_clr <= 1'b0;
        repeat (4) @(posedge clk);
        chk("second seen", s2, {27'h000_0000, second_seen});
        chk("third seen", s3, {12'h000, third_seen});
    endtask

    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(A_SECOND, 32'h0000_001F, 1'b0);
        rd(A_THIRD, THIRD_RESET, 1'b0);
        rd(A_CLEAR, 32'h0000_0000, 1'b0);
        chk_seen(32'h0000_001F, THIRD_RESET);
        for (int i = 0; i < THIRD_W; i++) begin
            wr(A_THIRD, 32'h0000_0001 << i, 1'b0);
            rd(A_THIRD, 32'h0000_0001 << i, 1'b0);
            chk("third en", 32'h0000_0001 << i, {12'h000, third_en});
        end
        for (int i = 0; i < SECOND_W; i++) begin
            wr(A_SECOND, 32'h0000_0001 << i, 1'b0);
            rd(A_SECOND, 32'h0000_0001 << i, 1'b0);
            chk("second en", 32'h0000_0001 << i, {27'h000_0000, second_en});
        end
        // reserved bits kept zero on write; readback must show them zero
        wr(A_SECOND, 32'h0000_001F, 1'b0);
        wr(A_THIRD, 32'h000F_FFFF, 1'b0);
        rd(A_SECOND, 32'h0000_001F, 1'b0);
        rd(A_THIRD, 32'h000F_FFFF, 1'b0);
        chk_seen(32'h0000_001F, 32'h000F_FFFF);
        wr(A_SECOND, 32'h0000_0000, 1'b0);
        wr(A_THIRD, 32'h0000_0000, 1'b0);
        chk_seen(32'h0000_0000, 32'h0000_0000);
        // flag with the enable off must stay silent
        clocks_settled <= 1'b1;
        @(posedge clk);
        clocks_settled <= 1'b0;
        chk_irq(1'b0);
        rd(A_STATUS, 32'h0000_0001, 1'b0);
        wr(A_SET, 32'h0000_0000, 1'b0);
        rd(A_CLEAR, 32'h0000_0000, 1'b0);
        wr(A_SET, 32'h0000_0001, 1'b0);
        rd(A_CLEAR, 32'h0000_0001, 1'b0);
        rd(A_SET, 32'h0000_0001, 1'b0);
        chk_irq(1'b1);
        wr(A_CLEAR, 32'h0000_0000, 1'b0);
        chk_irq(1'b1);
        wr(A_CLEAR, 32'h0000_0001, 1'b0);
        chk_irq(1'b0);
        rd(A_SET, 32'h0000_0000, 1'b0);
        wr(A_SET, 32'h0000_0001, 1'b0);
        chk_irq(1'b1);
        wr(A_STCLR, 32'h0000_0000, 1'b0);
        chk_irq(1'b1);
        wr(A_STCLR, 32'h0000_0001, 1'b0);
        chk_irq(1'b0);
        rd(A_STATUS, 32'h0000_0000, 1'b0);
        // settle while enabled raises the request; settle beats a same-cycle clear
        clocks_settled <= 1'b1;
        @(posedge clk);
        clocks_settled <= 1'b0;
        chk_irq(1'b1);
        clocks_settled <= 1'b1;
        wr(A_STCLR, 32'h0000_0001, 1'b0);
        clocks_settled <= 1'b0;
        rd(A_STATUS, 32'h0000_0001, 1'b0);
        wr(A_STCLR, 32'h0000_0001, 1'b0);
        chk_irq(1'b0);
        // locked writes are refused and leave state alone
        write_lock <= 1'b1;
        wr(A_SECOND, 32'h0000_001F, 1'b1);
        wr(A_CLEAR, 32'h0000_0001, 1'b1);
        rd(A_SECOND, 32'h0000_0000, 1'b0);
        rd(A_SET, 32'h0000_0001, 1'b0);
        write_lock <= 1'b0;
        wr(A_SECOND, 32'h0000_0005, 1'b0);
        rd(A_SECOND, 32'h0000_0005, 1'b0);
        rd(8'h04, 32'h0000_0000, 1'b1);
        // second reset in mid-run restores every default
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        chk("second en", 32'h0000_001F, {27'h000_0000, second_en});
        chk("third en", THIRD_RESET, {12'h000, third_en});
        chk("irq", 32'h0000_0000, {31'h0000_0000, irq});
        rst_b <= 1'b1;
        repeat (4) @(posedge clk);
        rd(A_SET, 32'h0000_0000, 1'b0);
        close_out();
    end
endmodule

`default_nettype wire
